/* verilog/ibs_top.sv */
// two-wire bus controller: APB registers, master and slave bit engines
// assumes open-drain pins resolved outside; waitMode, stopMode on clk
`timescale 1ns/1ps
`default_nettype none
`include "ibs_regs.svh"
module ibs_top (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus pins
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // low power modes
  input wire logic waitMode,
  input wire logic stopMode,
  // interrupt
  output logic irq
);
  logic [1:0] rstPipe;
  logic rstN;
  logic sclMeta, sclS, sclD, sdaMeta, sdaS, sdaD;
  logic sclRise, sclFall, startSeen, stopSeen;
  logic setup, access, wr, rd, mapped;
  logic hitAddr, hitDiv, hitCtrl, hitStat, hitData, hitMask, hitIrq;
  logic wrData, rdData;
  logic [7:0] rdMux, ctrlRd, statRd;
  logic [7:1] ownAddr;
  logic [7:0] divCode, dataReg;
  logic moduleEnable, interruptEnable, masterSelect, txMode;
  logic ackLevelSelect, repeatStartRequest, stopInWait;
  logic [2:0] mask, istat, events;
  logic transfer_complete_flag, busBusy, rxAck;
  logic freeze, run;
  ibs_pkg::ibs_mstate_t mState;
  ibs_pkg::ibs_count_t cnt;
  logic [3:0] bitIdx;
  logic [7:0] mShift;
  logic mSclLow, mSdaLow, bitLow;
  logic hiEnd, mDone, arbBit, arbLost, idleReq, go, rsTake;
  logic hiDone, lowEnd, holdHit;
  logic sOn, sMe, sAddrPh, sTx, sAckIn, sSdaLow;
  logic [3:0] sBit;
  logic [7:0] sShift;
  logic sFall7, addrHit, sDone;
  logic sdaDrv;

  ibs_timing_if tif ();
  ibs_timing u_timing (
    .clk(clk),
    .rstN(rstN),
    .tif(tif)
  );
  assign tif.code = divCode;

  // reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rstPipe <= 2'h0;
    else rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstN = rstPipe[1];

  // pin synchronisers and line events
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      {sclMeta, sclS, sclD} <= 3'h7;
      {sdaMeta, sdaS, sdaD} <= 3'h7;
    end else begin
      {sclMeta, sclS, sclD} <= {sclIn, sclMeta, sclS};
      {sdaMeta, sdaS, sdaD} <= {sdaIn, sdaMeta, sdaS};
    end
  end
  assign sclRise = sclS & !sclD;
  assign sclFall = !sclS & sclD;
  assign startSeen = sclS & sclD & sdaD & !sdaS;
  assign stopSeen = sclS & sclD & !sdaD & sdaS;

  assign freeze = stopMode | (waitMode & stopInWait);
  assign run = moduleEnable & !freeze;

  // apb decode
  assign setup = psel & !penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & !pwrite;
  assign hitAddr = paddr == `IBS_OFS_ADDR;
  assign hitDiv = paddr == `IBS_OFS_DIV;
  assign hitCtrl = paddr == `IBS_OFS_CTRL;
  assign hitStat = paddr == `IBS_OFS_STAT;
  assign hitData = paddr == `IBS_OFS_DATA;
  assign hitMask = paddr == `IBS_OFS_MASK;
  assign hitIrq = paddr == `IBS_OFS_IRQ;
  assign mapped = hitAddr | hitDiv | hitCtrl | hitStat | hitData |
                  hitMask | hitIrq;
  assign wrData = wr & hitData;
  assign rdData = rd & hitData;
  assign pready = 1'b1;
  assign pslverr = access & !mapped;

  assign ctrlRd = {moduleEnable, interruptEnable, masterSelect, txMode,
                   ackLevelSelect, 2'h0, stopInWait};
  assign statRd = {transfer_complete_flag, sMe, busBusy, istat[`IBS_IRQ_AL], 1'b0, sTx,
                   |istat, rxAck};
  assign rdMux = hitAddr ? {ownAddr, 1'b0} :
                 hitDiv ? divCode :
                 hitCtrl ? ctrlRd :
                 hitStat ? statRd :
                 hitData ? dataReg :
                 hitMask ? {5'h00, mask} :
                 hitIrq ? {5'h00, istat} : 8'h00;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) prdata <= 32'h0000_0000;
    else if (setup) prdata <= {24'h000000, rdMux};
  end

  // configuration registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ownAddr <= 7'(`IBS_RST_BYTE >> 1);
      divCode <= `IBS_RST_BYTE;
      mask <= 3'h0;
    end else begin
      if (wr & hitAddr) ownAddr <= pwdata[7:1];
      if (wr & hitDiv) divCode <= pwdata[7:0];
      if (wr & hitMask) mask <= pwdata[2:0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      moduleEnable <= 1'b0;
      interruptEnable <= 1'b0;
      masterSelect <= 1'b0;
      txMode <= 1'b0;
      ackLevelSelect <= 1'b0;
      repeatStartRequest <= 1'b0;
      stopInWait <= 1'b0;
    end else begin
      if (wr & hitCtrl) begin
        moduleEnable <= pwdata[`IBS_CTRL_EN];
        interruptEnable <= pwdata[`IBS_CTRL_IE];
        masterSelect <= pwdata[`IBS_CTRL_MSL];
        txMode <= pwdata[`IBS_CTRL_TX];
        ackLevelSelect <= pwdata[`IBS_CTRL_ACK];
        repeatStartRequest <= pwdata[`IBS_CTRL_REPEAT_START_REQUEST];
        stopInWait <= pwdata[`IBS_CTRL_SWAI];
      end
      if (arbLost) masterSelect <= 1'b0;
      if (rsTake) repeatStartRequest <= 1'b0;
    end
  end

  // data byte: software writes, received bytes land here
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) dataReg <= `IBS_RST_BYTE;
    else if (wrData) dataReg <= pwdata[7:0];
    else if (mDone & !txMode) dataReg <= mShift;
    else if (sDone & !sTx) dataReg <= sShift;
  end

  // status flags, sticky events, interrupt
  assign events = {arbLost, addrHit, mDone | sDone};
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      istat <= 3'h0;
      transfer_complete_flag <= `IBS_RST_TCF;
      busBusy <= 1'b0;
      rxAck <= 1'b0;
      irq <= 1'b0;
    end else begin
      istat <= (istat & ~((wr & hitIrq) ? pwdata[2:0] : 3'h0)) | events;
      if (mDone | sDone) transfer_complete_flag <= 1'b1;
      else if (go) transfer_complete_flag <= 1'b0;
      if (startSeen) busBusy <= 1'b1;
      else if (stopSeen) busBusy <= 1'b0;
      if (mDone) rxAck <= sdaS;
      else if (sDone & sTx) rxAck <= sAckIn;
      irq <= interruptEnable & moduleEnable & |(istat & ~mask);
    end
  end

  // master engine
  // high phase counts from the synchronised line, two clocks late
  assign hiDone = cnt >= tif.sclHalf - 16'h0003;
  assign lowEnd = cnt >= tif.sclHalf - 16'h0001;
  // data pin lags the hold count by one register
  assign holdHit = cnt == tif.sdaHold - 16'h0002;
  assign hiEnd = run & (mState == ibs_pkg::MS_HIGH) & sclS & hiDone;
  assign mDone = hiEnd & (bitIdx == `IBS_ACK_BIT);
  assign arbBit = hiEnd & txMode & (bitIdx < `IBS_ACK_BIT) & !mSdaLow &
                  !sdaS;
  assign idleReq = run & (mState == ibs_pkg::MS_IDLE) & masterSelect;
  assign arbLost = (idleReq & busBusy) | arbBit;
  assign rsTake = run & (mState == ibs_pkg::MS_WAIT) & masterSelect &
                  repeatStartRequest;
  assign go = run & (mState == ibs_pkg::MS_WAIT) & masterSelect &
              !repeatStartRequest & (wrData | (rdData & !txMode));
  assign bitLow = (bitIdx == `IBS_ACK_BIT) ? (!txMode & !ackLevelSelect) :
                  (txMode & !mShift[7]);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mState <= ibs_pkg::MS_IDLE;
      cnt <= 16'h0000;
      bitIdx <= 4'h0;
      mShift <= 8'h00;
      mSclLow <= 1'b0;
      mSdaLow <= 1'b0;
    end else if (!moduleEnable) begin
      mState <= ibs_pkg::MS_IDLE;
      mSclLow <= 1'b0;
      mSdaLow <= 1'b0;
    end else if (!freeze) begin
      case (mState)
        ibs_pkg::MS_IDLE: if (masterSelect & !busBusy) begin
          mSdaLow <= 1'b1;
          cnt <= 16'h0000;
          mState <= ibs_pkg::MS_START;
        end
        ibs_pkg::MS_START: if (cnt >= tif.startHold) begin
          mSclLow <= 1'b1;
          mState <= ibs_pkg::MS_WAIT;
        end else cnt <= cnt + 16'h0001;
        ibs_pkg::MS_WAIT: begin
          cnt <= 16'h0000;
          if (!masterSelect) mState <= ibs_pkg::MS_STOPL;
          else if (repeatStartRequest) mState <= ibs_pkg::MS_RSL;
          else if (go) begin
            bitIdx <= 4'h0;
            mShift <= wrData ? pwdata[7:0] : 8'hff;
            mState <= ibs_pkg::MS_LOW;
          end
        end
        ibs_pkg::MS_LOW: begin
          cnt <= cnt + 16'h0001;
          if (holdHit) mSdaLow <= bitLow;
          if (lowEnd) begin
            mSclLow <= 1'b0;
            cnt <= 16'h0000;
            mState <= ibs_pkg::MS_HIGH;
          end
        end
        ibs_pkg::MS_HIGH: if (!sclS) cnt <= 16'h0000;
        else if (hiDone) begin
          cnt <= 16'h0000;
          if (arbBit) begin
            mSdaLow <= 1'b0;
            mState <= ibs_pkg::MS_IDLE;
          end else begin
            mSclLow <= 1'b1;
            if (bitIdx == `IBS_ACK_BIT) mState <= ibs_pkg::MS_WAIT;
            else begin
              bitIdx <= bitIdx + 4'h1;
              mShift <= {mShift[6:0], sdaS};
              mState <= ibs_pkg::MS_LOW;
            end
          end
        end else cnt <= cnt + 16'h0001;
        ibs_pkg::MS_STOPL: begin
          cnt <= cnt + 16'h0001;
          if (holdHit) mSdaLow <= 1'b1;
          if (lowEnd) begin
            mSclLow <= 1'b0;
            cnt <= 16'h0000;
            mState <= ibs_pkg::MS_STOPH;
          end
        end
        ibs_pkg::MS_STOPH: if (!sclS) cnt <= 16'h0000;
        else if (cnt >= tif.stopHold) begin
          mSdaLow <= 1'b0;
          mState <= ibs_pkg::MS_IDLE;
        end else cnt <= cnt + 16'h0001;
        ibs_pkg::MS_RSL: begin
          cnt <= cnt + 16'h0001;
          if (holdHit) mSdaLow <= 1'b0;
          if (lowEnd) begin
            mSclLow <= 1'b0;
            cnt <= 16'h0000;
            mState <= ibs_pkg::MS_RSH;
          end
        end
        ibs_pkg::MS_RSH: if (!sclS) cnt <= 16'h0000;
        else if (cnt >= tif.startHold) begin
          mSdaLow <= 1'b1;
          cnt <= 16'h0000;
          mState <= ibs_pkg::MS_START;
        end else cnt <= cnt + 16'h0001;
        default: mState <= ibs_pkg::MS_IDLE;
      endcase
    end
  end

  // slave engine
  assign sFall7 = run & sOn & sclFall & (sBit == 4'h7);
  assign addrHit = sFall7 & sAddrPh & (sShift[7:1] == ownAddr) &
                   (mState == ibs_pkg::MS_IDLE);
  assign sDone = sFall7 & !sAddrPh & sMe;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      {sOn, sMe, sAddrPh, sTx, sAckIn, sSdaLow} <= 6'h00;
      sBit <= 4'h0;
      sShift <= 8'h00;
    end else if (!moduleEnable) begin
      {sOn, sMe, sSdaLow} <= 3'h0;
    end else if (!freeze) begin
      if (startSeen) begin
        {sOn, sMe, sAddrPh, sSdaLow} <= 4'ha;
        // the fall that follows a start wraps the count to bit 0
        sBit <= 4'hf;
      end else if (stopSeen) begin
        {sOn, sMe, sSdaLow} <= 3'h0;
      end else if (sOn & sclRise) begin
        if (sBit < `IBS_ACK_BIT) sShift <= {sShift[6:0], sdaS};
        else sAckIn <= sdaS;
      end else if (sOn & sclFall) begin
        if (sBit == 4'h7) begin
          sBit <= `IBS_ACK_BIT;
          sAddrPh <= 1'b0;
          if (addrHit) begin
            sMe <= 1'b1;
            sTx <= sShift[0];
            sAckIn <= 1'b0;
            sSdaLow <= 1'b1;
          end else if (sAddrPh) sOn <= 1'b0;
          else sSdaLow <= sMe & !sTx & !ackLevelSelect;
        end else if (sBit == `IBS_ACK_BIT) begin
          sBit <= 4'h0;
          if (sMe & sTx & !sAckIn) begin
            sShift <= dataReg;
            sSdaLow <= !dataReg[7];
          end else sSdaLow <= 1'b0;
        end else begin
          sBit <= sBit + 4'h1;
          sSdaLow <= sMe & sTx & !sShift[7];
        end
      end
    end
  end

  // open-drain pins: enable pulls the line low
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) sdaDrv <= 1'b0;
    else sdaDrv <= (mSdaLow | sSdaLow) & moduleEnable;
  end
  assign sdaOe = sdaDrv;
  assign sclOe = mSclLow;
  assign sdaOut = 1'b0;
  assign sclOut = 1'b0;

  AST_BIT0_ZERO:
  assert property (@(posedge clk) disable iff (!rstN)
    setup && hitAddr |=> prdata[0] == 1'b0)
    else $error("own address bit 0 read back as one");
  AST_ARB_DROP:
  assert property (@(posedge clk) disable iff (!rstN)
    arbLost |=> !masterSelect && istat[`IBS_IRQ_AL])
    else $error("arbitration loss kept master mode or lost flag");
  AST_CALL_FLAG:
  assert property (@(posedge clk) disable iff (!rstN)
    addrHit |=> sMe && istat[`IBS_IRQ_AAS])
    else $error("own address call not flagged");
  AST_OWN_MATCH:
  assert property (@(posedge clk) disable iff (!rstN)
    $rose(sMe) |-> $past(sShift[7:1]) == ownAddr)
    else $error("addressed on a foreign address");
  AST_BUSY_SET:
  assert property (@(posedge clk) disable iff (!rstN)
    startSeen |=> busBusy)
    else $error("start seen but bus not busy");
  AST_STRETCH:
  assert property (@(posedge clk) disable iff (!rstN)
    run && mState == ibs_pkg::MS_HIGH && !sclS |=> cnt == 16'h0000)
    else $error("high phase counted while clock held low");
  AST_FREEZE:
  assert property (@(posedge clk) disable iff (!rstN)
    moduleEnable && freeze |=> $stable(mState) && $stable(cnt))
    else $error("master engine moved while frozen");
  AST_RELEASE:
  assert property (@(posedge clk) disable iff (!rstN)
    !moduleEnable |=> !sclOe && !sdaOe)
    else $error("pins driven while disabled");
  AST_SLAVE_ACK:
  assert property (@(posedge clk) disable iff (!rstN)
    sDone && !sTx |=> sSdaLow == !$past(ackLevelSelect))
    else $error("slave data ack level wrong");
  AST_IDLE_SLAVE:
  assert property (@(posedge clk) disable iff (!rstN)
    mState == ibs_pkg::MS_IDLE |-> ##1 !sclOe || mState != ibs_pkg::MS_IDLE)
    else $error("clock pulled while idle");
endmodule : ibs_top
`default_nettype wire

/* verilog/ibs_regs.svh */
// register offsets, field positions, reset values and timing constants
// assumes an APB slave with byte addresses, one register per 32-bit word
`ifndef IBS_REGS_SVH
`define IBS_REGS_SVH
`define IBS_OFS_ADDR 8'h00
`define IBS_OFS_DIV 8'h04
`define IBS_OFS_CTRL 8'h08
`define IBS_OFS_STAT 8'h0c
`define IBS_OFS_DATA 8'h10
`define IBS_OFS_MASK 8'h14
`define IBS_OFS_IRQ 8'h18
`define IBS_CTRL_EN 7
`define IBS_CTRL_IE 6
`define IBS_CTRL_MSL 5
`define IBS_CTRL_TX 4
`define IBS_CTRL_ACK 3
`define IBS_CTRL_REPEAT_START_REQUEST 2
`define IBS_CTRL_SWAI 0
`define IBS_IRQ_TC 0
`define IBS_IRQ_AAS 1
`define IBS_IRQ_AL 2
`define IBS_RST_BYTE 8'h00
`define IBS_RST_TCF 1'b1
`define IBS_ACK_BIT 4'h8
`define IBS_PERIOD_ADD 16'h0002
`define IBS_HOLD_ADD 16'h0003
`define IBS_MIN_HALF 16'h000a
`endif

/* verilog/ibs_pkg.sv */
// types shared by the two-wire controller files
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package ibs_pkg;
  typedef logic [15:0] ibs_count_t;
  typedef enum logic [3:0] {
    MS_IDLE = 4'h0,
    MS_START = 4'h1,
    MS_WAIT = 4'h2,
    MS_LOW = 4'h3,
    MS_HIGH = 4'h4,
    MS_STOPL = 4'h5,
    MS_STOPH = 4'h6,
    MS_RSL = 4'h7,
    MS_RSH = 4'h8
  } ibs_mstate_t;
endpackage : ibs_pkg
`default_nettype wire

/* verilog/ibs_timing_if.sv */
// divider code in, decoded bit timing counts out
// assumes ibs_pkg is compiled first
`timescale 1ns/1ps
`default_nettype none
interface ibs_timing_if;
  logic [7:0] code;
  ibs_pkg::ibs_count_t sclHalf;
  ibs_pkg::ibs_count_t sdaHold;
  ibs_pkg::ibs_count_t startHold;
  ibs_pkg::ibs_count_t stopHold;
  modport gen (input code, output sclHalf, sdaHold, startHold, stopHold);
  modport host (output code, input sclHalf, sdaHold, startHold, stopHold);
endinterface : ibs_timing_if
`default_nettype wire

/* verilog/ibs_timing.sv */
// bit-rate divider decode: half period, data hold, start and stop holds
// assumes clk and an active-low reset already synchronised by the top
`timescale 1ns/1ps
`default_nettype none
`include "ibs_regs.svh"
module ibs_timing (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // timing values
  ibs_timing_if.gen tif
);
  function automatic logic [3:0] sclTapOf(input logic [2:0] c);
    case (c)
      3'h0: sclTapOf = 4'h5;
      3'h1: sclTapOf = 4'h6;
      3'h2: sclTapOf = 4'h7;
      3'h3: sclTapOf = 4'h8;
      3'h4: sclTapOf = 4'h9;
      3'h5: sclTapOf = 4'ha;
      3'h6: sclTapOf = 4'hc;
      default: sclTapOf = 4'hf;
    endcase
  endfunction : sclTapOf

  // first tap, start offset, stop offset packed per spacing code
  function automatic logic [23:0] offsOf(input logic [2:0] c);
    case (c)
      3'h0: offsOf = 24'h040207;
      3'h1: offsOf = 24'h040207;
      3'h2: offsOf = 24'h060209;
      3'h3: offsOf = 24'h060609;
      3'h4: offsOf = 24'h0e0e11;
      3'h5: offsOf = 24'h1e1e21;
      3'h6: offsOf = 24'h3e3e41;
      default: offsOf = 24'h7e7e81;
    endcase
  endfunction : offsOf

  logic [3:0] sclTap;
  logic [2:0] sdaTap;
  logic [23:0] offs;
  logic [1:0] mulSh;
  logic [15:0] sclOfs;
  logic [15:0] sdaOfs;
  logic [15:0] halfBase;
  logic [15:0] sdaBase;
  logic [15:0] startBase;
  logic [15:0] stopBase;

  assign sclTap = sclTapOf(tif.code[2:0]);
  assign sdaTap = {1'b0, tif.code[2:1]} + 3'h1;
  assign offs = offsOf(tif.code[5:3]);
  // spacing is two to the power of the code
  assign sclOfs = {12'h000, sclTap - 4'h1} << tif.code[5:3];
  assign sdaOfs = {13'h0, sdaTap - 3'h1} << tif.code[5:3];
  // reserved multiplier code behaves as four
  assign mulSh = (tif.code[7:6] == 2'h0) ? 2'h0 :
                 (tif.code[7:6] == 2'h1) ? 2'h1 : 2'h2;
  assign halfBase = {8'h00, offs[23:16]} + sclOfs + `IBS_PERIOD_ADD;
  assign sdaBase = {8'h00, offs[23:16]} + sdaOfs + `IBS_HOLD_ADD;
  assign startBase = {8'h00, offs[15:8]} + sclOfs;
  assign stopBase = {8'h00, offs[7:0]} + sclOfs;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tif.sclHalf <= `IBS_MIN_HALF;
      tif.sdaHold <= 16'h0000;
      tif.startHold <= 16'h0000;
      tif.stopHold <= 16'h0000;
    end else begin
      tif.sclHalf <= halfBase << mulSh;
      tif.sdaHold <= sdaBase << mulSh;
      tif.startHold <= startBase << mulSh;
      tif.stopHold <= stopBase << mulSh;
    end
  end

  AST_MIN_RATE:
  assert property (@(posedge clk) disable iff (!rstN)
    tif.sclHalf >= `IBS_MIN_HALF)
    else $error("bit clock faster than one twentieth of clk");
  AST_PERIOD_X2:
  assert property (@(posedge clk) disable iff (!rstN)
    tif.code == 8'h40 |=> tif.sclHalf == 16'h0014)
    else $error("doubled period wrong for code 40");
  AST_HOLD_3F:
  assert property (@(posedge clk) disable iff (!rstN)
    tif.code == 8'h3f |=> tif.sdaHold == 16'h0201)
    else $error("data hold wrong for code 3f");
  AST_START_STOP:
  assert property (@(posedge clk) disable iff (!rstN)
    tif.code == 8'h23 |=>
      tif.startHold == 16'h007e && tif.stopHold == 16'h0081)
    else $error("start or stop hold wrong for code 23");
endmodule : ibs_timing
`default_nettype wire

/* sim/ibs_bus_model.sv */
// far-side bus party: pull-ups, line resolution and a simple bus master
// assumes the design drives its pins as open drain through its oe outputs
`timescale 1ns/1ps
`default_nettype none
module ibs_bus_model (
  // clock
  input wire logic clk,
  // design pin enables
  input wire logic dutSclOe,
  input wire logic dutSdaOe,
  // resolved lines
  output logic sclLine,
  output logic sdaLine
);
  logic sclLow = 1'b0;
  logic sdaLow = 1'b0;
  // pull-up wins unless any party pulls low
  assign sclLine = !(dutSclOe || sclLow);
  assign sdaLine = !(dutSdaOe || sdaLow);
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold
  task automatic drive(input logic c, input logic s, input int n);
    sclLow <= c;
    sdaLow <= s;
    hold(n);
  endtask : drive
  task automatic start_cond;
    drive(1'b0, 1'b1, 20);
    drive(1'b1, 1'b1, 20);
  endtask : start_cond
  // msb first, then one released bit sampled mid high phase
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      drive(1'b1, !b[i], 10);
      drive(1'b0, !b[i], 20);
    end
    drive(1'b1, 1'b0, 10);
    drive(1'b0, 1'b0, 10);
    ack = sdaLine;
    drive(1'b0, 1'b0, 10);
    drive(1'b1, 1'b0, 10);
  endtask : send_byte
  task automatic stop_cond;
    drive(1'b1, 1'b1, 10);
    drive(1'b0, 1'b1, 20);
    drive(1'b0, 1'b0, 20);
  endtask : stop_cond
endmodule : ibs_bus_model
`default_nettype wire

/* sim/ibs_top_tb.sv */
// self-checking bench: APB register tests, slave call, arbitration, master
// assumes ibs_pkg, ibs_timing_if, ibs_timing and ibs_top compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ibs_regs.svh"
module ibs_top_tb;
  localparam int LOW_EXP = 10;
  localparam int HIGH_EXP = 10;
  localparam int HOLD_EXP = 7;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic waitMode = 1'b0;
  logic stopMode = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sclOut;
  logic sclOe;
  logic sdaOut;
  logic sdaOe;
  logic irq;
  logic sclLine;
  logic sdaLine;
  logic lastErr;
  logic ack;
  logic [31:0] d;
  int error_cnt = 0;
  int compares = 0;
  int n;
  int m;
  ibs_top ibs_top_i (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclIn(sclLine), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .waitMode(waitMode), .stopMode(stopMode), .irq(irq));
  ibs_bus_model ibs_bus_model_i (.clk(clk), .dutSclOe(sclOe),
    .dutSdaOe(sdaOe), .sclLine(sclLine), .sdaLine(sdaLine));
  initial begin
    forever #20 clk = !clk;
  end
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    apb(`IBS_OFS_STAT, 1'b0, 32'h0, d);
    chk("stat_reset", 32'h80, d);
    apb(`IBS_OFS_ADDR, 1'b1, 32'hff, d);
    apb(`IBS_OFS_ADDR, 1'b0, 32'h0, d);
    chk("own_addr_bit0", 32'hfe, d);
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 32'h40 : (i == 1) ? 32'h3f : 32'h23;
      apb(`IBS_OFS_DIV, 1'b1, n, d);
      apb(`IBS_OFS_DIV, 1'b0, 32'h0, d);
      chk("divider_rw", n, d);
    end
    apb(8'h1c, 1'b0, 32'h0, d);
    chk("unmapped_err", 32'h1, {31'h0, lastErr});
    chk("unmapped_read", 32'h0, d);
    apb(`IBS_OFS_DIV, 1'b1, 32'h0, d);
    apb(`IBS_OFS_ADDR, 1'b1, 32'h52, d);
    apb(`IBS_OFS_CTRL, 1'b1, 32'hc0, d);
    ibs_bus_model_i.start_cond();
    ibs_bus_model_i.send_byte(8'h52, ack);
    chk("slave_ack", 32'h0, {31'h0, ack});
    ibs_bus_model_i.send_byte(8'h3c, ack);
    chk("slave_data_ack", 32'h0, {31'h0, ack});
    apb(`IBS_OFS_DATA, 1'b0, 32'h0, d);
    chk("slave_data_byte", 32'h3c, d);
    apb(`IBS_OFS_STAT, 1'b0, 32'h0, d);
    chk("addressed_busy", 32'h3, {30'h0, d[6:5]});
    chk("irq_addressed", 32'h1, {31'h0, irq});
    apb(`IBS_OFS_MASK, 1'b1, 32'h7, d);
    apb(`IBS_OFS_IRQ, 1'b0, 32'h0, d);
    chk("irq_status_bit", 32'h1, {31'h0, d[1]});
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(`IBS_OFS_MASK, 1'b1, 32'h0, d);
    apb(`IBS_OFS_IRQ, 1'b1, 32'h7, d);
    apb(`IBS_OFS_IRQ, 1'b0, 32'h0, d);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    ibs_bus_model_i.stop_cond();
    apb(`IBS_OFS_STAT, 1'b0, 32'h0, d);
    chk("busy_after_stop", 32'h0, {31'h0, d[5]});
    ibs_bus_model_i.start_cond();
    ibs_bus_model_i.send_byte(8'h54, ack);
    chk("other_addr_nack", 32'h1, {31'h0, ack});
    apb(`IBS_OFS_CTRL, 1'b1, 32'ha0, d);
    apb(`IBS_OFS_CTRL, 1'b0, 32'h0, d);
    chk("arb_master_dropped", 32'h0, {31'h0, d[5]});
    apb(`IBS_OFS_STAT, 1'b0, 32'h0, d);
    chk("arb_lost_flag", 32'h1, {31'h0, d[4]});
    ibs_bus_model_i.stop_cond();
    apb(`IBS_OFS_IRQ, 1'b1, 32'h7, d);
    apb(`IBS_OFS_CTRL, 1'b1, 32'hf0, d);
    repeat (40) @(posedge clk);
    apb(`IBS_OFS_DATA, 1'b1, 32'ha4, d);
    while (sclOe !== 1'b0) @(negedge clk);
    while (sclOe !== 1'b1) @(negedge clk);
    n = 0;
    m = 0;
    while (sclOe === 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
      if (sdaOe === 1'b1 && m == 0) m = n;
    end
    chk("scl_low_half", LOW_EXP, n);
    chk("sda_hold", HOLD_EXP, m);
    n = 0;
    while (sclOe === 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("scl_high_half", HIGH_EXP, n);
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    apb(`IBS_OFS_STAT, 1'b0, 32'h0, d);
    chk("tcf_nack", 32'h3, {30'h0, d[7], d[0]});
    apb(`IBS_OFS_CTRL, 1'b1, 32'hc1, d);
    waitMode <= 1'b1;
    repeat (40) @(posedge clk);
    apb(`IBS_OFS_STAT, 1'b0, 32'h0, d);
    chk("wait_frozen_busy", 32'h1, {31'h0, d[5]});
    waitMode <= 1'b0;
    stopMode <= 1'b1;
    repeat (40) @(posedge clk);
    apb(`IBS_OFS_STAT, 1'b0, 32'h0, d);
    chk("stop_frozen_busy", 32'h1, {31'h0, d[5]});
    stopMode <= 1'b0;
    repeat (100) @(posedge clk);
    apb(`IBS_OFS_STAT, 1'b0, 32'h0, d);
    chk("stop_not_busy", 32'h0, {31'h0, d[5]});
    wrap_up();
  end
endmodule : ibs_top_tb
`default_nettype wire
